// [inc/clock_select_pkg.sv]
// Purpose: Constants for the dual video/memory clock selection logic.
// Assumes: System clock of 100 MHz; frequencies are held in kHz.
// Notes:   Index of each table is the selection code.
package clock_select_pkg;
	// System clock rate in kHz, used to scale the synthesiser steps
	localparam int unsigned SYS_CLK_KHZ = 100000;
	// Reference clock rate in kHz, 14.318 MHz
	localparam int unsigned REF_CLK_KHZ = 14318;
	// Time without a reference edge before the reference counts as lost, in ns and in cycles
	localparam int unsigned REF_LOSS_NS = 200;
	localparam int unsigned REF_LOSS_CYC = REF_LOSS_NS * SYS_CLK_KHZ / 1000000;
	// Width of a frequency word in kHz
	localparam int unsigned FREQ_W = 17;
	// Latched low video-select bits after reset, as if pulled up
	localparam logic [1:0] VID_LOW_RESET = 2'h3;
	// Video code that passes the external clock through
	localparam logic [3:0] VID_EXT_CODE = 4'h2;
	// Video frequencies in kHz by code; the external entry is zero
	localparam logic [16:0] VIDEO_KHZ [16] = '{
		17'h07530, 17'h12dc2, 17'h00000, 17'h13880,
		17'h07b0c, 17'h08ca0, 17'h124f8, 17'h0c350,
		17'h09c40, 17'h0c350, 17'h07d00, 17'h0af64,
		17'h06257, 17'h06ea2, 17'h0fde8, 17'h08ca0};
	// Memory frequencies in kHz by code
	localparam logic [16:0] MEMORY_KHZ [8] = '{
		17'h080e8, 17'h0c350, 17'h0ea60, 17'h07724,
		17'h09c40, 17'h0927c, 17'h08ca0, 17'h0af64};
	// Phase step of a 32-bit accumulator for a frequency in kHz
	function automatic logic [31:0] dds_step_type_f(input logic [16:0] khz);
		logic [63:0] prod;
		prod = ({47'h0, khz} << 32) / 64'(SYS_CLK_KHZ);
		return prod[31:0];
	endfunction : dds_step_type_f
endpackage : clock_select_pkg

// [logic/dual_clock_select_logic.sv]
// Purpose: Selection and output control of a dual video/memory clock source.
// Assumes: All pins sampled on clk_sys; pulled-up pins appear as ones.
// Notes:   The analog loops are modelled by phase accumulators; outputs
//          above half the system rate alias, so frequency words are exact
//          and the clock pins are only approximate.
`timescale 1ns/10ps

// Behaviour
// - Clock pins come from system-clock accumulators that run only while the reference toggles; the video pin on code 0010 passes the external clock.
// - Video code: two direct, two latched bits.
// - Strobe low captures low bits; otherwise hold.
// - Fifteen internal frequencies, code 0010 external.
// - Video codes 0-7 frequency table.
// - Video codes 8-15 frequency table.
// - Memory clock chosen by three-bit code table.
// - Each clock output has its own enable.
// - Undriven inputs read high; all-ones defaults.
module dual_clock_select_logic (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// Video selection from system bus and controller
	input  wire logic        video_select_bit0,
	input  wire logic        video_select_bit1,
	input  wire logic        video_select_bit2,
	input  wire logic        video_select_bit3,
	input  wire logic        select_latch_strobe_n,
	// Memory selection
	input  wire logic [2:0]  memory_select_bits,
	// Clock inputs, sampled
	input  wire logic        reference_clock_in,
	input  wire logic        external_clock_in,
	// Output enables
	input  wire logic        video_out_enable,
	input  wire logic        memory_out_enable,
	// Video clock pin
	output logic             video_dot_clock_out,
	output logic             video_dot_clock_oe,
	// Memory clock pin
	output logic             memory_clock_out,
	output logic             memory_clock_oe,
	// Chosen frequencies in kHz; the video word is zero on pass-through
	output logic [16:0]      video_freq_khz,
	output logic [16:0]      memory_freq_khz
);
	logic [1:0]  low_sel_q;      // Latched low video-select bits
	logic [3:0]  video_code;     // Effective video code
	logic        ref_prev_q;     // Previous reference sample
	logic [7:0]  ref_idle_q;     // Cycles since last reference edge
	logic        ref_ok;         // Reference is toggling
	logic [31:0] vid_acc_q;      // Video phase accumulator
	logic [31:0] mem_acc_q;      // Memory phase accumulator
	logic        armed_q;        // Checks live from second edge on

	// Latch follows while strobe is low, holds while high; a short
	// pulse is enough since every cycle of it captures
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			low_sel_q <= clock_select_pkg::VID_LOW_RESET;
		end else if (!select_latch_strobe_n) begin
			low_sel_q <= {video_select_bit1, video_select_bit0};
		end
	end

	// High bits act directly, low bits come from the latch
	assign video_code = {video_select_bit3, video_select_bit2,
		low_sel_q};

	// Reference activity watch; synthesis stops without a reference
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			ref_prev_q <= 1'b1;
			ref_idle_q <= 8'h00;
		end else begin
			ref_prev_q <= reference_clock_in;
			if (reference_clock_in && !ref_prev_q) begin
				ref_idle_q <= 8'h00;
			end else if (ref_idle_q !=
				8'(clock_select_pkg::REF_LOSS_CYC)) begin
				ref_idle_q <= ref_idle_q + 8'h01;
			end
		end
	end
	// Reference considered present until the idle count saturates
	assign ref_ok = (ref_idle_q != 8'(clock_select_pkg::REF_LOSS_CYC));

	// Frequency words follow the current codes; a new code takes the
	// new word on the next edge with no glitch guard
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			video_freq_khz  <= clock_select_pkg::VIDEO_KHZ[15];
			memory_freq_khz <= clock_select_pkg::MEMORY_KHZ[7];
		end else begin
			video_freq_khz  <= clock_select_pkg::VIDEO_KHZ[video_code];
			memory_freq_khz <=
				clock_select_pkg::MEMORY_KHZ[memory_select_bits];
		end
	end

	// Accumulators only advance while the reference runs
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			vid_acc_q <= 32'h0;
			mem_acc_q <= 32'h0;
		end else if (ref_ok) begin
			vid_acc_q <= vid_acc_q +
				clock_select_pkg::dds_step_type_f(video_freq_khz);
			mem_acc_q <= mem_acc_q +
				clock_select_pkg::dds_step_type_f(memory_freq_khz);
		end
	end

	// Output pins: source mux and enables registered together
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			video_dot_clock_out <= 1'b0;
			video_dot_clock_oe  <= 1'b1;
			memory_clock_out    <= 1'b0;
			memory_clock_oe     <= 1'b1;
		end else begin
			// Pass-through adds one cycle of delay to the external clock
			if (video_code == clock_select_pkg::VID_EXT_CODE) begin
				video_dot_clock_out <= external_clock_in;
			end else begin
				video_dot_clock_out <= vid_acc_q[31];
			end
			memory_clock_out   <= mem_acc_q[31];
			video_dot_clock_oe <= video_out_enable;
			memory_clock_oe    <= memory_out_enable;
		end
	end

	// Assertion guard: a reset released on a clock edge still runs the
	// reset branch at that edge, so checks against the prior cycle would
	// see a word that was never loaded; they start one edge later
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
		end
	end

	// Held latch while strobe is high
	latch_hold_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		$past(select_latch_strobe_n) |-> low_sel_q == $past(low_sel_q))
		else $error("low select bits changed without strobe");
	// Capture during strobe low
	latch_capture_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		!select_latch_strobe_n |=>
			low_sel_q == $past({video_select_bit1, video_select_bit0}))
		else $error("low select bits not captured");
	// High bits direct into the word next cycle
	high_direct_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		##1 video_freq_khz == clock_select_pkg::VIDEO_KHZ[{
			$past(video_select_bit3), $past(video_select_bit2),
			$past(low_sel_q)}])
		else $error("video word not from direct and latched bits");
	// Pass-through follows external clock
	ext_pass_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		video_code == clock_select_pkg::VID_EXT_CODE |=>
			video_dot_clock_out == $past(external_clock_in))
		else $error("external clock not passed through");
	// External code carries no internal frequency word
	ext_word_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		video_code == clock_select_pkg::VID_EXT_CODE |=>
			video_freq_khz == 17'h00000)
		else $error("external code left a frequency word");
	// Sample entries of the video table
	video_table_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		video_code == 4'h1 |=> video_freq_khz == 17'h12dc2)
		else $error("video code 1 not 77.25 MHz");
	video_high_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		video_code == 4'hc |=> video_freq_khz == 17'h06257)
		else $error("video code 12 not 25.175 MHz");
	// Memory table entries
	memory_table_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		memory_select_bits == 3'h3 |=> memory_freq_khz == 17'h07724)
		else $error("memory code 3 not 30.5 MHz");
	memory_low_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		memory_select_bits == 3'h0 |=> memory_freq_khz == 17'h080e8)
		else $error("memory code 0 not 33.0 MHz");
	// Enables reach the pins one cycle later
	out_enable_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		##1 (video_dot_clock_oe == $past(video_out_enable)) &&
			(memory_clock_oe == $past(memory_out_enable)))
		else $error("output enable not applied");
	// Accumulators freeze without a reference
	ref_stop_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		!ref_ok |=> $stable(mem_acc_q))
		else $error("memory synthesis ran without reference");
	video_stop_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		!ref_ok |=> $stable(vid_acc_q))
		else $error("video synthesis ran without reference");
	// Memory pin shows the accumulator top bit one cycle on
	memory_pin_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		##1 memory_clock_out == $past(mem_acc_q[31]))
		else $error("memory pin not from its synthesiser");
	// New memory code switches its word within one cycle
	code_switch_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		$changed(memory_select_bits) |=> memory_freq_khz ==
			clock_select_pkg::MEMORY_KHZ[$past(memory_select_bits)])
		else $error("memory word did not follow new code");
	// New video code switches its word within one cycle
	video_switch_a: assert property (
		@(posedge clk_sys) disable iff (!nrst || !armed_q)
		$changed(video_code) |=> video_freq_khz ==
			clock_select_pkg::VIDEO_KHZ[$past(video_code)])
		else $error("video word did not follow new code");
endmodule : dual_clock_select_logic

// [bench/clk_source_model.sv]
// Purpose: Far-side model giving the reference and external clocks.
// Assumes: Free-running board clocks, changed on rising clk_sys.
// Notes:   Reference period is seven system cycles, near 14.3 MHz.
`timescale 1ns/10ps
module clk_source_model (
	// System clock
	input  wire logic clk_sys,
	// Test control: holds the reference low to model its loss
	input  wire logic ref_hold,
	// Board clocks toward the device
	output logic      reference_clock_in,
	output logic      external_clock_in
);
	logic [2:0] phase_q; // Place within the reference period
	// One process drives the pins: known levels at time zero, then
	// edges well inside the loss window unless the reference is held
	initial begin
		phase_q = 3'h0;
		reference_clock_in = 1'h0;
		external_clock_in = 1'h0;
		forever begin
			@(posedge clk_sys);
			phase_q <= (phase_q == 3'h6) ? 3'h0 : phase_q + 3'h1;
			reference_clock_in <= ref_hold ? 1'h0 : (phase_q < 3'h4);
			external_clock_in <= phase_q[1];
		end
	end
endmodule : clk_source_model

// [bench/tb.sv]
// Purpose: Self-checking bench for the clock selection logic.
// Assumes: Inputs change on rising clk_sys by non-blocking assignment.
// Notes:   Frequency words are checked, not pin periods, which alias.
`timescale 1ns/10ps
module tb;
	logic       clk_sys, nrst, video_select_bit0, video_select_bit1;
	logic       video_select_bit2, video_select_bit3, select_latch_strobe_n;
	logic       video_out_enable, memory_out_enable, ext_prev;
	logic [2:0] memory_select_bits;
	logic       reference_clock_in, external_clock_in;
	logic       video_dot_clock_out, video_dot_clock_oe;
	logic       memory_clock_out, memory_clock_oe;
	logic [16:0] video_freq_khz, memory_freq_khz;
	int         errors, checks;
	logic       ref_hold;      // Holds the reference low
	logic [1:0] pins_held;     // Pin levels once the reference stopped
	int         toggles;       // Memory pin changes after restart
	// Expected kHz by code
	logic [16:0] vid_exp [16] = '{17'h07530, 17'h12dc2, 17'h00000,
		17'h13880, 17'h07b0c, 17'h08ca0, 17'h124f8, 17'h0c350, 17'h09c40,
		17'h0c350, 17'h07d00, 17'h0af64, 17'h06257, 17'h06ea2, 17'h0fde8,
		17'h08ca0};
	logic [16:0] mem_exp [8] = '{17'h080e8, 17'h0c350, 17'h0ea60,
		17'h07724, 17'h09c40, 17'h0927c, 17'h08ca0, 17'h0af64};
	clk_source_model src (.clk_sys, .ref_hold, .reference_clock_in,
		.external_clock_in);
	dual_clock_select_logic uut (.clk_sys, .nrst, .video_select_bit0,
		.video_select_bit1, .video_select_bit2, .video_select_bit3,
		.select_latch_strobe_n, .memory_select_bits, .reference_clock_in,
		.external_clock_in, .video_out_enable, .memory_out_enable,
		.video_dot_clock_out, .video_dot_clock_oe, .memory_clock_out,
		.memory_clock_oe, .video_freq_khz, .memory_freq_khz);
	// 100 MHz system clock
	initial begin
		clk_sys = 1'h0;
		forever #5 clk_sys = ~clk_sys;
	end
	// External level one edge back, as the pass-through shows it
	always @(posedge clk_sys) ext_prev <= external_clock_in;
	// Compare and count
	task automatic cmp(input logic [16:0] got, input logic [16:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// Video code write; low bits pass only when the strobe pulses
	task automatic vid(input logic [3:0] c, input logic stb,
		input logic [3:0] eff);
		@(posedge clk_sys);
		{video_select_bit3, video_select_bit2} <= c[3:2];
		{video_select_bit1, video_select_bit0} <= c[1:0];
		select_latch_strobe_n <= ~stb;
		@(posedge clk_sys);
		select_latch_strobe_n <= 1'h1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp(video_freq_khz, vid_exp[eff]);
	endtask : vid
	// Counts, verdict and end of run
	task automatic test_done;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : test_done
	// Watchdog against a hang
	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		test_done();
	end
	// Main sequence; undriven pins are pulled up, so idle inputs sit high
	initial begin
		{nrst, memory_select_bits} = 4'h7;
		{video_select_bit3, video_select_bit2} = 2'h3;
		{video_select_bit1, video_select_bit0} = 2'h3;
		{select_latch_strobe_n, video_out_enable, memory_out_enable} = 3'h7;
		ref_hold = 1'h0;
		nrst = 1'h0;
		repeat (12) @(posedge clk_sys);
		@(negedge clk_sys);
		cmp(video_freq_khz, 17'h08ca0);
		cmp(memory_freq_khz, 17'h0af64);
		cmp({video_dot_clock_oe, memory_clock_oe}, 17'h3);
		@(posedge clk_sys) nrst <= 1'h1;
		for (int i = 0; i < 16; i++) vid(4'(i), 1'h1, 4'(i));
		vid(4'h4, 1'h0, 4'h7);
		$display("video codes done");
		vid(4'h2, 1'h1, 4'h2);
		repeat (8) @(negedge clk_sys) cmp(video_dot_clock_out, ext_prev);
		$display("pass-through done");
		for (int m = 0; m < 8; m++) begin
			@(posedge clk_sys) memory_select_bits <= 3'(m);
			repeat (2) @(posedge clk_sys);
			@(negedge clk_sys) cmp(memory_freq_khz, mem_exp[m]);
		end
		$display("memory codes done");
		for (int e = 3; e >= 0; e--) begin
			@(posedge clk_sys) {video_out_enable, memory_out_enable} <= 2'(e);
			@(posedge clk_sys);
			@(negedge clk_sys);
			cmp({video_dot_clock_oe, memory_clock_oe}, 17'(e));
		end
		@(posedge clk_sys) nrst <= 1'h0;
		@(negedge clk_sys) cmp(video_freq_khz, 17'h08ca0);
		cmp({video_dot_clock_oe, memory_clock_oe}, 17'h3);
		repeat (2) @(posedge clk_sys);
		nrst <= 1'h1;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys) cmp(video_freq_khz, vid_exp[3]);
		$display("enables and reset done");
		@(posedge clk_sys) ref_hold <= 1'h1;
		repeat (30) @(posedge clk_sys);
		@(negedge clk_sys) pins_held = {video_dot_clock_out, memory_clock_out};
		repeat (8) @(negedge clk_sys)
			cmp({video_dot_clock_out, memory_clock_out}, 17'(pins_held));
		@(posedge clk_sys) ref_hold <= 1'h0;
		repeat (12) @(posedge clk_sys);
		toggles = 0;
		repeat (4) begin
			@(negedge clk_sys);
			if (memory_clock_out !== pins_held[0]) toggles++;
		end
		cmp(17'(toggles != 0), 17'h1);
		$display("reference loss done");
		test_done();
	end
endmodule : tb
